// file: hw/sct_transfer_ctrl.sv
`timescale 1ns/100ps
module sct_transfer_ctrl #(
  parameter int WORDS = sct_pkg::CFG_WORDS,
  parameter int WIDTH = sct_pkg::CFG_WIDTH
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic master_mode, // Pin, 1 = self boot
  input wire logic master_clk_tick, // Master clock pulse
  input wire sct_pkg::sct_wr_t wr, // Shadow write port
  input wire logic primary, // Frame is a primary load
  input wire logic permit_pin, // Transfer permit pin
  input wire sct_pkg::sct_timing_t timing, // Timing cell setup
  input wire logic cmp_in, // Comparator output
  input wire logic sar_in, // Converter output
  input wire logic ext_trig_pin, // External event pin
  input wire logic [sct_pkg::NUM_CLKS-1:0] chip_clk_pin, // Chip clocks
  input wire logic [1:0] logic_in_pin, // Cell logic inputs
  input wire logic [sct_pkg::LUT_ADDR_W-1:0] lut_addr, // Table index
  input wire logic [WORDS-1:0] lut_enable, // Words overridden
  input wire logic lut_we, // Table write
  input wire logic [WIDTH-1:0] lut_wdata, // Table data
  input wire logic [sct_pkg::SEL_W-1:0] sel_a, // Output A select
  input wire logic [sct_pkg::SEL_W-1:0] sel_b, // Output B select
  input wire logic inv_a, // Output A invert
  input wire logic inv_b, // Output B invert
  output logic [WORDS*WIDTH-1:0] active_cfg, // Image to analog core
  output logic [1:0] module_ctrl, // Logic to analog modules
  output logic xfer_done, // Transfer done
  output logic primary_done, // Primary image active
  output logic cfg_error, // Two external sources chosen
  output logic out_a, // Cell output A
  output logic out_b // Cell output B
);
  localparam int AW = $clog2(WORDS);

  // All state of this module except the table memory
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] shadow;
    logic [WORDS-1:0][WIDTH-1:0] active;
    logic pending;         // Shadow holds unsent data
    logic pend_primary;    // Pending data is a primary load
    logic primary_done;
    logic frame_d;
    logic done;
    logic armed;
    logic trig_d;
    logic allclk_d;
    logic [sct_pkg::DIV_W-1:0] div;
    logic [1:0][sct_pkg::NUM_CLKS+4-1:0] sync;
    logic [WIDTH-1:0] lut_q;
  } sct_state_t;

  sct_state_t st_reg, st_next;
  logic [WIDTH-1:0] lut_mem [sct_pkg::LUT_DEPTH];
  logic cfg_tick, frame_end, trig, arm, all_clk, fire, bad_src, new_img;
  logic [sct_pkg::NUM_CLKS-1:0] clk_s;
  logic ext_s, permit_s;
  logic [1:0] lin_s;

  // ****************************************************************
  // Table memory
  // ****************************************************************
  // Kept outside the state struct so it can map to a RAM
  always_ff @(posedge clk) begin
    if (lut_we) begin
      lut_mem[lut_addr] <= lut_wdata;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // Two-stage sync of all pin inputs but master_mode; only stage 2 is read below
    st_next.sync[0] = {logic_in_pin, permit_pin, ext_trig_pin, chip_clk_pin};
    st_next.sync[1] = st_reg.sync[0];
    {lin_s, permit_s, ext_s, clk_s} = st_reg.sync[1];
    st_next.lut_q = lut_mem[lut_addr];

    // Master mode steps on a divided tick, slave on every clock
    cfg_tick = 1'b1;
    if (master_mode) begin
      cfg_tick = master_clk_tick &&
        (st_reg.div == sct_pkg::DIV_W'(sct_pkg::MASTER_DIV - 1));
    end
    if (master_mode && master_clk_tick) begin
      st_next.div = st_reg.div + sct_pkg::DIV_W'(1);
    end

    frame_end = st_reg.frame_d && !wr.frame;
    if (cfg_tick) begin
      st_next.frame_d = wr.frame;
    end

    // Shadow only; active left alone by a write
    if (cfg_tick && wr.we && (primary || st_reg.primary_done)) begin
      st_next.shadow[wr.addr[AW-1:0]] = wr.data;
    end
    // A refused frame before the primary load asks for no copy
    new_img = cfg_tick && frame_end && (primary || st_reg.primary_done);
    if (new_img) begin
      st_next.pending = 1'b1;
      st_next.pend_primary = primary;
    end

    // Trigger terms and the external-source conflict
    bad_src = timing.trig_ext && timing.arm_ext;
    trig = timing.trig_ext ? ext_s : cmp_in;
    arm = timing.arm_ext ? ext_s : cmp_in;
    st_next.trig_d = trig;
    all_clk = &clk_s;
    st_next.allclk_d = all_clk;
    if (!st_reg.pending) begin
      st_next.armed = 1'b0;
    end else if (arm) begin
      st_next.armed = 1'b1;
    end

    fire = 1'b0;
    if (st_reg.pending) begin
      if (st_reg.pend_primary) begin
        fire = permit_s;
      end else begin
        case (timing.mode)
          sct_pkg::SCT_IMMEDIATE: fire = 1'b1;
          sct_pkg::SCT_EVENT: fire = trig && !st_reg.trig_d;
          sct_pkg::SCT_ARMED:
            fire = st_reg.armed && trig && !st_reg.trig_d && !bad_src;
          sct_pkg::SCT_CLKSYNC:
            fire = all_clk && !st_reg.allclk_d;
          default: fire = 1'b0;
        endcase
      end
    end

    // Whole image in one cycle
    if (fire) begin
      st_next.active = st_reg.shadow;
      st_next.pending = new_img; // A frame ending now keeps its copy
      st_next.done = 1'b1;
      if (st_reg.pend_primary) begin
        st_next.primary_done = 1'b1;
      end
    end else if (cfg_tick && wr.frame && !st_reg.frame_d) begin
      st_next.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Table override costs one word mux per location
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      active_cfg[i*WIDTH +: WIDTH] = lut_enable[i] ?
        st_reg.lut_q : st_reg.active[i];
    end
  end

  assign module_ctrl = lin_s;
  assign xfer_done = st_reg.done;
  assign primary_done = st_reg.primary_done;
  assign cfg_error = bad_src;

  // Two routed outputs per cell
  sct_out_route u_out_a (
    .clk(clk), .rst(rst), .chip_clk(clk_s), .cmp_in(cmp_in),
    .sar_in(sar_in), .done_in(st_reg.done), .sel(sel_a),
    .invert(inv_a), .pin_out(out_a)
  );
  sct_out_route u_out_b (
    .clk(clk), .rst(rst), .chip_clk(clk_s), .cmp_in(cmp_in),
    .sar_in(sar_in), .done_in(st_reg.done), .sel(sel_b),
    .invert(inv_b), .pin_out(out_b)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_copy_one_cycle: assert property (
    @(posedge clk) disable iff (rst)
    fire |=> st_reg.active == $past(st_reg.shadow))
    else $error("copy not in one cycle");
  chk_active_holds: assert property (
    @(posedge clk) disable iff (rst)
    !fire |=> $stable(st_reg.active))
    else $error("active changed without copy");
  chk_permit_gate: assert property (
    @(posedge clk) disable iff (rst)
    (st_reg.pending && st_reg.pend_primary && !permit_s) |=>
      !st_reg.done || $past(st_reg.done))
    else $error("primary copy without permit");
  // Immediate mode never leaves a non-primary image pending for more than one cycle
  chk_immediate_mode: assert property (
    @(posedge clk) disable iff (rst)
    (st_reg.pending && !st_reg.pend_primary &&
     timing.mode == sct_pkg::SCT_IMMEDIATE) |-> fire)
    else $error("immediate copy late");
  // Trigger rise rebuilt from the sources, not from the stored copy
  chk_event_edge: assert property (
    @(posedge clk) disable iff (rst)
    (fire && !st_reg.pend_primary && timing.mode == sct_pkg::SCT_EVENT)
      |-> $rose(timing.trig_ext ? ext_s : cmp_in))
    else $error("event copy without trigger");
  chk_armed_gate: assert property (
    @(posedge clk) disable iff (rst)
    (fire && !st_reg.pend_primary && timing.mode == sct_pkg::SCT_ARMED)
      |-> st_reg.armed && !cfg_error &&
        $rose(timing.trig_ext ? ext_s : cmp_in))
    else $error("armed copy without arm");
  chk_clk_align: assert property (
    @(posedge clk) disable iff (rst)
    (fire && !st_reg.pend_primary && timing.mode == sct_pkg::SCT_CLKSYNC)
      |-> $rose(&clk_s))
    else $error("copy off clock alignment");
  chk_done_follows: assert property (
    @(posedge clk) disable iff (rst)
    fire |=> xfer_done)
    else $error("done missing after copy");
  chk_master_div: assert property (
    @(posedge clk) disable iff (rst)
    (master_mode && cfg_tick) |->
      st_reg.div == sct_pkg::DIV_W'(sct_pkg::MASTER_DIV - 1))
    else $error("master tick not divided");
  // Sixteen master ticks apart, and a tick comes at most once a cycle
  chk_master_gap: assert property (
    @(posedge clk) disable iff (rst)
    (master_mode && cfg_tick) |=> (!cfg_tick || !master_mode) [*8]
      ##1 (!cfg_tick || !master_mode) [*7])
    else $error("master steps too close");
  chk_table_override: assert property (
    @(posedge clk) disable iff (rst)
    lut_enable[0] |-> active_cfg[WIDTH-1:0] == st_reg.lut_q)
    else $error("table override lost");

  cov_primary_copy: cover property (@(posedge clk)
    fire && st_reg.pend_primary);
  cov_event_copy: cover property (@(posedge clk)
    fire && timing.mode == sct_pkg::SCT_EVENT);
  cov_sync_copy: cover property (@(posedge clk)
    fire && timing.mode == sct_pkg::SCT_CLKSYNC);
  cov_armed_copy: cover property (@(posedge clk)
    fire && timing.mode == sct_pkg::SCT_ARMED);
endmodule

// file: hw/sct_pkg.sv
package sct_pkg;
  // Behaviour
  // - The whole shadow image is copied into the active image in one clock cycle.
  // - Written data lands only in shadow memory and active memory is untouched until a copy is enabled.
  // - After a primary load the copy waits until the permit pin is high.
  // - After a primary load, further data may be written to shadow while the active image runs.
  // - Immediate mode copies as soon as the reconfiguration write ends.
  // - Event mode copies on a chosen internal or external trigger.
  // - Armed event mode lets an arm term gate the trigger, and at most one of them is external.
  // - Clock synchronised mode copies only when all chip clocks first become high together.
  // - Each of two cell outputs selects a chip clock, a comparator or converter output, or transfer done.
  // - Each cell output has a programmable polarity.
  // - Two independent logic inputs are routed into the analog modules.
  // - Table memory may override chosen active configuration locations.
  // - In master mode the configuration logic advances on master clock divided by 16.

  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int NUM_CLKS = 6;
  localparam int CFG_WORDS = 16;
  localparam int CFG_WIDTH = 8;
  localparam int ADDR_W = 4;
  localparam int LUT_DEPTH = 256;
  localparam int LUT_ADDR_W = 8;
  localparam int MASTER_DIV = 16;
  localparam int DIV_W = 4;

  // ****************************************************************
  // Timing cell modes and output selects
  // ****************************************************************
  typedef enum logic [1:0] {
    SCT_IMMEDIATE, SCT_EVENT, SCT_ARMED, SCT_CLKSYNC
  } sct_mode_t;

  localparam logic [2:0] SEL_CMP = 3'h6;
  localparam logic [2:0] SEL_SAR = 3'h7;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_DONE = 4'h8;

  // Trigger configuration of the timing cell
  typedef struct packed {
    sct_mode_t mode;
    logic trig_ext;   // Trigger from pin, else comparator
    logic arm_ext;    // Arm from pin, else comparator
  } sct_timing_t;

  // Write port from serial front end
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [CFG_WIDTH-1:0] data;
    logic frame;      // Write frame open
  } sct_wr_t;
endpackage

// file: hw/sct_out_route.sv
`timescale 1ns/100ps
module sct_out_route (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic [sct_pkg::NUM_CLKS-1:0] chip_clk, // Chip clocks
  input wire logic cmp_in, // Comparator
  input wire logic sar_in, // Converter bit
  input wire logic done_in, // Transfer done
  input wire logic [sct_pkg::SEL_W-1:0] sel, // Source select
  input wire logic invert, // Polarity
  output logic pin_out // Routed output
);
  typedef struct packed {
    logic q;
  } sct_or_state_t;
  sct_or_state_t st_reg, st_next;
  logic src;

  // ****************************************************************
  // Source pick and polarity
  // ****************************************************************
  // Clocks are pre-synchronised by the caller; one cycle of delay is kept
  always_comb begin
    src = 1'b0;
    if (sel < sct_pkg::SEL_W'(sct_pkg::NUM_CLKS)) begin
      src = chip_clk[sel[2:0]];
    end else if (sel == {1'b0, sct_pkg::SEL_CMP}) begin
      src = cmp_in;
    end else if (sel == {1'b0, sct_pkg::SEL_SAR}) begin
      src = sar_in;
    end else if (sel == sct_pkg::SEL_DONE) begin
      src = done_in;
    end
    st_next.q = src ^ invert;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.q;

  chk_polarity_route: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> pin_out == ($past(src) ^ $past(invert)))
    else $error("routed output wrong");
endmodule

// file: bench/sct_host_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Host processor on the serial configuration port
// ****************************************************************
module sct_host_model (
  input wire logic clk, // Clock
  output sct_pkg::sct_wr_t wr, // Shadow write port
  output logic primary // Frame is a primary load
);
  // Idle port at time zero
  initial begin
    wr = '0;
    primary = 1'b0;
  end

  // One word per frame, strobe held n cycles; host is the serial master
  // Released lines carry the inverse so a stale word cannot pass
  task automatic send(input logic [3:0] a, input logic [7:0] d,
                      input logic p, input int n);
    @(posedge clk);
    wr <= '{1'b1, a, d, 1'b1};
    primary <= p;
    repeat (n) @(posedge clk);
    wr.we <= 1'b0;
    @(posedge clk);
    wr <= '{1'b0, ~a, ~d, 1'b0};
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

// file: bench/shadow_config_transfer_control_bench.sv
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench for the transfer control block
// ****************************************************************
module shadow_config_transfer_control_bench;
  logic clk, rst, master_clk_tick, primary, permit_pin, cmp_in, sar_in;
  logic ext_trig_pin, lut_we, inv_a, inv_b, master_mode;
  sct_pkg::sct_wr_t wr;
  sct_pkg::sct_timing_t timing;
  logic [5:0] chip_clk_pin;
  logic [1:0] logic_in_pin, module_ctrl;
  logic [7:0] lut_addr, lut_wdata;
  logic [15:0] lut_enable;
  logic [3:0] sel_a, sel_b;
  logic [127:0] active_cfg, img, nxt;
  logic xfer_done, primary_done, cfg_error, out_a, out_b;
  logic [7:0] src;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int hold = 1;

  sct_host_model host_u (.clk(clk), .wr(wr), .primary(primary));

  // Mode select stays low until the closing self-boot scenario
  sct_transfer_ctrl dut_u (.clk(clk), .rst(rst), .master_mode(master_mode),
    .master_clk_tick(master_clk_tick), .wr(wr), .primary(primary),
    .permit_pin(permit_pin), .timing(timing), .cmp_in(cmp_in),
    .sar_in(sar_in), .ext_trig_pin(ext_trig_pin),
    .chip_clk_pin(chip_clk_pin), .logic_in_pin(logic_in_pin),
    .lut_addr(lut_addr), .lut_enable(lut_enable), .lut_we(lut_we),
    .lut_wdata(lut_wdata), .sel_a(sel_a), .sel_b(sel_b), .inv_a(inv_a),
    .inv_b(inv_b), .active_cfg(active_cfg), .module_ctrl(module_ctrl),
    .xfer_done(xfer_done), .primary_done(primary_done),
    .cfg_error(cfg_error), .out_a(out_a), .out_b(out_b));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Master tick toggles so the input is not left constant
  always @(posedge clk) begin
    master_clk_tick <= ~master_clk_tick;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim;
    end
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the copy to be reported
  task automatic wait_done;
    int n;
    n = 0;
    while (xfer_done !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
  endtask

  // Shadow keeps accumulating words; img tracks the active image
  task automatic put(input logic [3:0] a, input logic [7:0] d,
                     input logic p);
    host_u.send(a, d, p, hold);
    nxt[8*a +: 8] = d;
  endtask

  task automatic set_mode(input sct_pkg::sct_mode_t m, input logic t,
                          input logic a);
    @(posedge clk);
    timing <= '{m, t, a};
    step(1);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    master_clk_tick = 1'b0;
    master_mode = 1'b0;
    permit_pin = 1'b0;
    timing = '0;
    cmp_in = 1'b0;
    sar_in = 1'b0;
    ext_trig_pin = 1'b0;
    chip_clk_pin = 6'h00;
    logic_in_pin = 2'h0;
    lut_addr = 8'h00;
    lut_enable = 16'h0000;
    lut_we = 1'b0;
    lut_wdata = 8'h00;
    sel_a = 4'h0;
    sel_b = 4'h0;
    inv_a = 1'b0;
    inv_b = 1'b0;
    img = '0;
    nxt = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    step(3);
    check(active_cfg, '0);
    check(xfer_done, 1'b0);
    host_u.send(4'h3, 8'h5a, 1'b0, hold);
    step(8);
    check(active_cfg, '0);
    check(xfer_done, 1'b0);
    put(4'h0, 8'hc3, 1'b1);
    step(8);
    check(active_cfg, '0);
    @(posedge clk);
    permit_pin <= 1'b1;
    wait_done;
    img = nxt;
    check(active_cfg, img);
    check(xfer_done, 1'b1);
    check(primary_done, 1'b1);
    put(4'hf, 8'ha5, 1'b0);
    wait_done;
    img = nxt;
    check(active_cfg, img);
    // Event mode: nothing moves until the pin rises
    set_mode(sct_pkg::SCT_EVENT, 1'b1, 1'b0);
    put(4'h1, 8'h96, 1'b0);
    step(8);
    check(xfer_done, 1'b0);
    check(active_cfg, img);
    @(posedge clk);
    ext_trig_pin <= 1'b1;
    wait_done;
    img = nxt;
    check(active_cfg, img);
    // Armed mode: a trigger without the arm is ignored
    set_mode(sct_pkg::SCT_ARMED, 1'b1, 1'b0);
    @(posedge clk);
    ext_trig_pin <= 1'b0;
    put(4'h2, 8'h3c, 1'b0);
    @(posedge clk);
    ext_trig_pin <= 1'b1;
    step(6);
    check(active_cfg, img);
    check(cfg_error, 1'b0);
    @(posedge clk);
    ext_trig_pin <= 1'b0;
    cmp_in <= 1'b1;
    step(6);
    @(posedge clk);
    ext_trig_pin <= 1'b1;
    wait_done;
    img = nxt;
    check(active_cfg, img);
    set_mode(sct_pkg::SCT_ARMED, 1'b1, 1'b1);
    check(cfg_error, 1'b1);
    // Clock sync: copy waits for all clocks high together
    set_mode(sct_pkg::SCT_CLKSYNC, 1'b0, 1'b0);
    @(posedge clk);
    chip_clk_pin <= 6'h15;
    put(4'h4, 8'h69, 1'b0);
    step(6);
    check(active_cfg, img);
    @(posedge clk);
    chip_clk_pin <= 6'h3f;
    wait_done;
    img = nxt;
    check(active_cfg, img);
    // Output routing over every source code, alternating polarity
    @(posedge clk);
    chip_clk_pin <= 6'h15;
    src = 8'h55;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sel_a <= 4'(i);
      inv_a <= 1'(i);
      step(5);
      check(out_a, src[i] ^ 1'(i));
    end
    @(posedge clk);
    sel_b <= sct_pkg::SEL_DONE;
    inv_b <= 1'b1;
    step(3);
    check(out_b, 1'b0);
    @(posedge clk);
    inv_b <= 1'b0;
    logic_in_pin <= 2'h2;
    step(5);
    check(out_b, 1'b1);
    check(module_ctrl, 2'h2);
    @(posedge clk);
    logic_in_pin <= 2'h1;
    step(5);
    check(module_ctrl, 2'h1);
    // Table word replaces active word 0 only while enabled
    @(posedge clk);
    lut_addr <= 8'h2a;
    lut_wdata <= 8'h81;
    lut_we <= 1'b1;
    @(posedge clk);
    lut_we <= 1'b0;
    @(posedge clk);
    lut_enable <= 16'h0001;
    step(3);
    check(active_cfg, {img[127:8], 8'h81});
    @(posedge clk);
    lut_enable <= 16'h0000;
    step(2);
    check(active_cfg, img);
    // Master mode: the write must outlast a sixteen tick step
    set_mode(sct_pkg::SCT_IMMEDIATE, 1'b0, 1'b0);
    @(posedge clk);
    master_mode <= 1'b1;
    hold = 40;
    put(4'h6, 8'h7e, 1'b0);
    wait_done;
    img = nxt;
    check(active_cfg, img);
    check(xfer_done, 1'b1);
    end_sim;
  end
endmodule
